// >>> rtl/instruction_timing_pkg.sv
package instruction_timing_pkg;

	// Widths of the cost arithmetic
	localparam int WORD_BITS = 24;
	localparam int CNT_W = 8;
	localparam int WAIT_W = 4;
	localparam int BUS_WAIT_W = 16;

	// Field positions in the bus wait control register, one nibble per space
	localparam int X_WAIT_LSB = 0;
	localparam int Y_WAIT_LSB = 4;
	localparam int P_WAIT_LSB = 8;
	localparam int IO_WAIT_LSB = 12;

	// Base costs, words and oscillator cycles
	localparam logic [CNT_W-1:0] BASE_WORDS = 8'h01;
	localparam logic [CNT_W-1:0] ALU_BASE_CYCLES = 8'h02;
	localparam logic [CNT_W-1:0] JUMP_BASE_CYCLES = 8'h04;
	localparam logic [CNT_W-1:0] PROG_MOVE_BASE_CYCLES = 8'h06;
	localparam logic [CNT_W-1:0] PERIPH_BASE_CYCLES = 8'h04;
	localparam logic [CNT_W-1:0] BIT_BASE_CYCLES = 8'h04;
	localparam logic [CNT_W-1:0] WAIT_OP_WORDS = 8'h01;
	localparam logic [CNT_W-1:0] WAIT_OP_MIN_CYCLES = 8'h10;

	// Instruction classes
	typedef enum logic [6:0]
	{
		CLS_ALU = 7'h01,
		CLS_CTRL_MOVE = 7'h02,
		CLS_PROG_MOVE = 7'h04,
		CLS_PERIPH_MOVE = 7'h08,
		CLS_BIT = 7'h10,
		CLS_JUMP = 7'h20,
		CLS_WAIT = 7'h40
	} instr_class_type;

	// Parallel move kinds
	typedef enum logic [1:0]
	{
		MV_NONE = 2'h0,
		MV_REG = 2'h1,
		MV_ONE_MEM = 2'h2,
		MV_DUAL_XY = 2'h3
	} move_kind_type;

	// Sequencer states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} seq_state_type;

endpackage : instruction_timing_pkg

// >>> rtl/wait_state_adder.sv
// Adds the wait states for one memory access when it leaves the chip
module wait_state_adder #(
	parameter int CNT_W = 8,
	parameter int WAIT_W = 4
) (
	input wire logic access_en,
	input wire logic access_external,
	input wire logic [WAIT_W-1:0] wait_count,
	output logic [CNT_W-1:0] extra_cycles
);

	// Elaboration check: the counter must hold a full wait field with room to add
	if (CNT_W <= WAIT_W)
	begin : g_width_check
		$error("Counter narrower than wait field");
	end

	// Internal accesses never stall
	always_comb
	begin
		if (access_en && access_external)
			extra_cycles = CNT_W'(wait_count);
		else
			extra_cycles = '0;
	end

endmodule : wait_state_adder

// >>> rtl/instruction_cycle_timing.sv
module instruction_cycle_timing #(
	parameter int CNT_W = instruction_timing_pkg::CNT_W
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic START,
	input wire instruction_timing_pkg::instr_class_type INSTR_CLASS,
	input wire logic IS_MAC_ROUND,
	input wire instruction_timing_pkg::move_kind_type MOVE_KIND,
	input wire logic OPERAND_FIELDS_PRESENT,
	input wire logic [2:0] EA_EXTRA_WORDS,
	input wire logic [2:0] EA_EXTRA_CYCLES,
	input wire logic [2:0] EA_EXTRA_CYCLES_B,
	input wire logic [2:0] CATEGORY_EXTRA,
	input wire logic X_ACCESS,
	input wire logic X_EXTERNAL,
	input wire logic Y_ACCESS,
	input wire logic Y_EXTERNAL,
	input wire logic P_ACCESS,
	input wire logic P_EXTERNAL,
	input wire logic IO_ACCESS,
	input wire logic IO_EXTERNAL,
	input wire logic PIPE_FLUSHED,
	input wire logic INTERNAL_IRQ_PENDING,
	input wire logic [15:0] BUS_WAIT_CONTROL,
	output logic [CNT_W-1:0] WORD_COUNT,
	output logic [CNT_W-1:0] CYCLE_COUNT,
	output logic ILLEGAL_ENCODING,
	output logic BUSY,
	output logic DONE
);

	// Elaboration check: narrower counts would wrap on the worst-case totals
	if (CNT_W < instruction_timing_pkg::CNT_W)
	begin : g_width_check
		$error("Count width too small for worst-case totals");
	end

	localparam int WW = instruction_timing_pkg::WAIT_W;

	logic [WW-1:0] x_wait_count;
	logic [WW-1:0] y_wait_count;
	logic [WW-1:0] p_wait_count;
	logic [WW-1:0] io_wait_count;
	logic [CNT_W-1:0] x_space_extra;
	logic [CNT_W-1:0] y_space_extra;
	logic [CNT_W-1:0] p_space_extra;
	logic [CNT_W-1:0] io_space_extra;
	logic [CNT_W-1:0] program_access_extra;
	logic [CNT_W-1:0] addressing_extra;
	logic [CNT_W-1:0] parallel_move_extra_words;
	logic [CNT_W-1:0] parallel_move_extra;
	logic [CNT_W-1:0] jump_extra;
	logic [CNT_W-1:0] words_d;
	logic [CNT_W-1:0] cycles_d;
	logic illegal_d;
	logic [CNT_W-1:0] remain_q;
	instruction_timing_pkg::seq_state_type state_q;

	// Wait fields of the bus wait control register, one per memory space
	assign x_wait_count = BUS_WAIT_CONTROL[instruction_timing_pkg::X_WAIT_LSB +: WW];
	assign y_wait_count = BUS_WAIT_CONTROL[instruction_timing_pkg::Y_WAIT_LSB +: WW];
	assign p_wait_count = BUS_WAIT_CONTROL[instruction_timing_pkg::P_WAIT_LSB +: WW];
	assign io_wait_count = BUS_WAIT_CONTROL[instruction_timing_pkg::IO_WAIT_LSB +: WW];

	// One adder per space; internal accesses contribute nothing
	wait_state_adder #(.CNT_W(CNT_W), .WAIT_W(WW)) x_adder (
		.access_en(X_ACCESS),
		.access_external(X_EXTERNAL),
		.wait_count(x_wait_count),
		.extra_cycles(x_space_extra)
	);
	wait_state_adder #(.CNT_W(CNT_W), .WAIT_W(WW)) y_adder (
		.access_en(Y_ACCESS),
		.access_external(Y_EXTERNAL),
		.wait_count(y_wait_count),
		.extra_cycles(y_space_extra)
	);
	wait_state_adder #(.CNT_W(CNT_W), .WAIT_W(WW)) p_adder (
		.access_en(P_ACCESS),
		.access_external(P_EXTERNAL),
		.wait_count(p_wait_count),
		.extra_cycles(p_space_extra)
	);
	wait_state_adder #(.CNT_W(CNT_W), .WAIT_W(WW)) io_adder (
		.access_en(IO_ACCESS),
		.access_external(IO_EXTERNAL),
		.wait_count(io_wait_count),
		.extra_cycles(io_space_extra)
	);

	// Program fetch waits only count when the pipe was flushed
	assign program_access_extra = PIPE_FLUSHED ? p_space_extra : '0;

	// Addressing extra; dual moves run both banks in parallel, so take the max
	always_comb
	begin
		if (MOVE_KIND == instruction_timing_pkg::MV_DUAL_XY && EA_EXTRA_CYCLES_B > EA_EXTRA_CYCLES)
			addressing_extra = CNT_W'(EA_EXTRA_CYCLES_B);
		else
			addressing_extra = CNT_W'(EA_EXTRA_CYCLES);
	end

	// Parallel move words and cycles by kind
	always_comb
	begin
		unique case (MOVE_KIND)
			instruction_timing_pkg::MV_NONE,
			instruction_timing_pkg::MV_REG:
			begin
				parallel_move_extra_words = '0;
				parallel_move_extra = '0;
			end
			instruction_timing_pkg::MV_ONE_MEM:
			begin
				parallel_move_extra_words = CNT_W'(EA_EXTRA_WORDS);
				parallel_move_extra = addressing_extra + x_space_extra + y_space_extra;
			end
			instruction_timing_pkg::MV_DUAL_XY:
			begin
				parallel_move_extra_words = '0;
				parallel_move_extra = addressing_extra + x_space_extra + y_space_extra;
			end
		endcase
	end

	// Jump extra: addressing plus two refill fetches
	assign jump_extra = addressing_extra + (program_access_extra << 1);

	// Totals per class: base plus every applicable extra term
	always_comb
	begin
		words_d = instruction_timing_pkg::BASE_WORDS;
		cycles_d = instruction_timing_pkg::ALU_BASE_CYCLES;
		illegal_d = 1'b0;
		unique case (INSTR_CLASS)
			instruction_timing_pkg::CLS_ALU:
			begin
				// Multiply-accumulate-round shares this cost form
				words_d = instruction_timing_pkg::BASE_WORDS + parallel_move_extra_words;
				cycles_d = instruction_timing_pkg::ALU_BASE_CYCLES + parallel_move_extra;
			end
			instruction_timing_pkg::CLS_CTRL_MOVE:
			begin
				words_d = instruction_timing_pkg::BASE_WORDS + CNT_W'(EA_EXTRA_WORDS);
				cycles_d = instruction_timing_pkg::ALU_BASE_CYCLES + CNT_W'(CATEGORY_EXTRA);
			end
			instruction_timing_pkg::CLS_PROG_MOVE:
			begin
				words_d = instruction_timing_pkg::BASE_WORDS + CNT_W'(EA_EXTRA_WORDS);
				cycles_d = instruction_timing_pkg::PROG_MOVE_BASE_CYCLES + addressing_extra
					+ p_space_extra;
			end
			instruction_timing_pkg::CLS_PERIPH_MOVE:
			begin
				words_d = instruction_timing_pkg::BASE_WORDS + CNT_W'(EA_EXTRA_WORDS);
				cycles_d = instruction_timing_pkg::PERIPH_BASE_CYCLES + CNT_W'(CATEGORY_EXTRA)
					+ io_space_extra;
			end
			instruction_timing_pkg::CLS_BIT:
			begin
				words_d = instruction_timing_pkg::BASE_WORDS + CNT_W'(EA_EXTRA_WORDS);
				cycles_d = instruction_timing_pkg::BIT_BASE_CYCLES + CNT_W'(CATEGORY_EXTRA);
			end
			instruction_timing_pkg::CLS_JUMP:
			begin
				words_d = instruction_timing_pkg::BASE_WORDS + CNT_W'(EA_EXTRA_WORDS);
				cycles_d = instruction_timing_pkg::JUMP_BASE_CYCLES + jump_extra;
			end
			instruction_timing_pkg::CLS_WAIT:
			begin
				// Fixed one word; operand bits present means a bad encoding
				words_d = instruction_timing_pkg::WAIT_OP_WORDS;
				illegal_d = OPERAND_FIELDS_PRESENT;
				if (INTERNAL_IRQ_PENDING)
					cycles_d = instruction_timing_pkg::WAIT_OP_MIN_CYCLES;
				else
					cycles_d = instruction_timing_pkg::ALU_BASE_CYCLES;
			end
			default:
			begin
				illegal_d = 1'b1;
			end
		endcase
		if (IS_MAC_ROUND && INSTR_CLASS != instruction_timing_pkg::CLS_ALU)
			illegal_d = 1'b1;
	end

	// Latch results on start; counts are in words and oscillator cycles
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			WORD_COUNT <= '0;
			CYCLE_COUNT <= '0;
			ILLEGAL_ENCODING <= 1'b0;
		end
		else if (START && state_q == instruction_timing_pkg::ST_IDLE)
		begin
			WORD_COUNT <= words_d;
			CYCLE_COUNT <= cycles_d;
			ILLEGAL_ENCODING <= illegal_d;
		end
	end

	// Sequencer: BUSY holds for the computed number of oscillator cycles
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q <= instruction_timing_pkg::ST_IDLE;
			remain_q <= '0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
		end
		else
		begin
			DONE <= 1'b0;
			unique case (state_q)
				instruction_timing_pkg::ST_IDLE:
				begin
					if (START)
					begin
						state_q <= instruction_timing_pkg::ST_BUSY;
						remain_q <= cycles_d; // Full count keeps BUSY up N cycles
						BUSY <= 1'b1;
					end
				end
				instruction_timing_pkg::ST_BUSY:
				begin
					if (remain_q <= 1)
					begin
						state_q <= instruction_timing_pkg::ST_IDLE;
						BUSY <= 1'b0;
						DONE <= 1'b1;
					end
					else
						remain_q <= remain_q - 1'b1;
				end
				default:
				begin
					state_q <= instruction_timing_pkg::ST_IDLE;
					BUSY <= 1'b0;
				end
			endcase
		end
	end

endmodule : instruction_cycle_timing

// >>> test/timing_props.sv
// Port-level checks of the timing sequencer
module timing_props #(
	parameter int CNT_W = 8
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic START,
	input wire instruction_timing_pkg::instr_class_type INSTR_CLASS,
	input wire logic IS_MAC_ROUND,
	input wire instruction_timing_pkg::move_kind_type MOVE_KIND,
	input wire logic OPERAND_FIELDS_PRESENT,
	input wire logic [2:0] EA_EXTRA_CYCLES,
	input wire logic INTERNAL_IRQ_PENDING,
	input wire logic P_ACCESS,
	input wire logic P_EXTERNAL,
	input wire logic PIPE_FLUSHED,
	input wire logic [15:0] BUS_WAIT_CONTROL,
	input wire logic [CNT_W-1:0] WORD_COUNT,
	input wire logic [CNT_W-1:0] CYCLE_COUNT,
	input wire logic ILLEGAL_ENCODING,
	input wire logic BUSY,
	input wire logic DONE
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// A request only counts while idle, so the request checks key on this
	logic take;
	logic wt;
	logic [3:0] refill_wait;
	assign take = START && !BUSY;
	// Refill fetches only stall when the pipe was flushed and program space is external
	assign refill_wait = (P_ACCESS && P_EXTERNAL && PIPE_FLUSHED)
		? BUS_WAIT_CONTROL[instruction_timing_pkg::P_WAIT_LSB +: 4] : 4'h0;
	assign wt = take && INSTR_CLASS == instruction_timing_pkg::CLS_WAIT;
	property p_take_busy;
		take |=> BUSY;
	endproperty
	a_take_busy: assert property (p_take_busy)
		else $error("busy not raised");
	property p_done_pulse;
		DONE |=> !DONE;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done too long");
	property p_fell_done;
		$fell(BUSY) |-> DONE;
	endproperty
	a_fell_done: assert property (p_fell_done)
		else $error("busy ended without done");
	// Counts stand between accepted requests
	property p_hold;
		!take |=> $stable(WORD_COUNT) && $stable(CYCLE_COUNT);
	endproperty
	a_hold: assert property (p_hold)
		else $error("counts moved");
	property p_wait_min;
		wt && INTERNAL_IRQ_PENDING && !OPERAND_FIELDS_PRESENT |=> BUSY[*8] ##1 BUSY[*8] ##1 DONE;
	endproperty
	a_wait_min: assert property (p_wait_min)
		else $error("wait too short");
	property p_wait_word;
		wt && !OPERAND_FIELDS_PRESENT && !IS_MAC_ROUND |=> WORD_COUNT == 1 && !ILLEGAL_ENCODING;
	endproperty
	a_wait_word: assert property (p_wait_word)
		else $error("wait word count");
	property p_wait_ops;
		wt && OPERAND_FIELDS_PRESENT |=> ILLEGAL_ENCODING;
	endproperty
	a_wait_ops: assert property (p_wait_ops)
		else $error("wait operands accepted");
	property p_mac_class;
		take && IS_MAC_ROUND && INSTR_CLASS != instruction_timing_pkg::CLS_ALU |=> ILLEGAL_ENCODING;
	endproperty
	a_mac_class: assert property (p_mac_class)
		else $error("round flag accepted");
	property p_dual_words;
		take && INSTR_CLASS == instruction_timing_pkg::CLS_ALU
			&& MOVE_KIND == instruction_timing_pkg::MV_DUAL_XY |=> WORD_COUNT == 1;
	endproperty
	a_dual_words: assert property (p_dual_words)
		else $error("dual move added words");
	// Two refill fetches each pay the program space waits
	property p_jump;
		take && INSTR_CLASS == instruction_timing_pkg::CLS_JUMP
			&& MOVE_KIND != instruction_timing_pkg::MV_DUAL_XY
			|=> int'(CYCLE_COUNT) == int'(instruction_timing_pkg::JUMP_BASE_CYCLES)
			+ int'($past(EA_EXTRA_CYCLES)) + 2 * int'($past(refill_wait));
	endproperty
	a_jump: assert property (p_jump)
		else $error("jump cycles");
	c_wait: cover property (wt && INTERNAL_IRQ_PENDING);
	c_jump: cover property (take && INSTR_CLASS == instruction_timing_pkg::CLS_JUMP);
	c_illegal: cover property (ILLEGAL_ENCODING);
endmodule : timing_props

// >>> test/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, start, mac, opf, xa, xe, ya, ye, pa, pe, ioa, ioe, flush, irq;
	instruction_timing_pkg::instr_class_type cls;
	instruction_timing_pkg::move_kind_type mk;
	logic [2:0] ea_w, ea_c, ea_b, cat;
	logic [15:0] bus_wait_control_register;
	logic [7:0] word_cnt, cyc_cnt;
	logic illegal, busy, done;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	instruction_cycle_timing u_instruction_cycle_timing (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.START(start), .INSTR_CLASS(cls), .IS_MAC_ROUND(mac), .MOVE_KIND(mk),
		.OPERAND_FIELDS_PRESENT(opf), .EA_EXTRA_WORDS(ea_w), .EA_EXTRA_CYCLES(ea_c),
		.EA_EXTRA_CYCLES_B(ea_b), .CATEGORY_EXTRA(cat), .X_ACCESS(xa), .X_EXTERNAL(xe),
		.Y_ACCESS(ya), .Y_EXTERNAL(ye), .P_ACCESS(pa), .P_EXTERNAL(pe), .IO_ACCESS(ioa),
		.IO_EXTERNAL(ioe), .PIPE_FLUSHED(flush), .INTERNAL_IRQ_PENDING(irq),
		.BUS_WAIT_CONTROL(bus_wait_control_register), .WORD_COUNT(word_cnt), .CYCLE_COUNT(cyc_cnt),
		.ILLEGAL_ENCODING(illegal), .BUSY(busy), .DONE(done));
	// Free running 40 MHz oscillator
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Neutral inputs; start is left alone so it is never set twice in one step
	task automatic clr;
		{mac, opf, xa, xe, ya, ye, pa, pe, ioa, ioe, flush, irq} = 12'h000;
		{ea_w, ea_c, ea_b, cat} = 12'h000;
		cls = instruction_timing_pkg::CLS_ALU;
		mk = instruction_timing_pkg::MV_NONE;
		bus_wait_control_register = 16'h0000;
	endtask : clr
	// Issue at a falling edge; in full runs over three cycles a stray start mid-run must be ignored
	task automatic go(input string nm, input logic [7:0] ew, input logic [7:0] ec,
		input logic ei, input bit full);
		int k;
		start = 1'b1;
		@(negedge clk_sys);
		start = 1'b0;
		k = 1;
		chk("illegal", {7'h00, ei}, {7'h00, illegal});
		if (full)
		begin
			chk("words", ew, word_cnt);
			chk("cycles", ec, cyc_cnt);
			chk("busy", 8'h01, {7'h00, busy});
		end
		while (done !== 1'b1 && k < 300)
		begin
			if (full && ec > 8'h03 && k > 1)
				start = (k == 2);
			@(negedge clk_sys);
			k++;
		end
		if (full)
			chk("done edge", ec + 8'h01, 8'(k));
		$display("%s finished", nm);
	endtask : go
	task automatic t_walk;
		clr();
		mac = 1'b1;
		mk = instruction_timing_pkg::MV_DUAL_XY;
		{xa, ya, ye} = 3'b111;
		bus_wait_control_register = 16'h0010;
		go("round_dual", 8'h01, 8'h03, 1'b0, 1'b1);
	endtask : t_walk
	task automatic t_dual_max;
		clr();
		mk = instruction_timing_pkg::MV_DUAL_XY;
		{ea_w, ea_c, ea_b} = 9'o213;
		{xa, ya} = 2'b11;
		bus_wait_control_register = 16'h00ff;
		go("dual_max", 8'h01, 8'h05, 1'b0, 1'b1);
	endtask : t_dual_max
	task automatic t_one_mem;
		clr();
		mk = instruction_timing_pkg::MV_ONE_MEM;
		{ea_w, ea_c} = 6'o11;
		{xa, xe} = 2'b11;
		bus_wait_control_register = 16'h0003;
		go("one_mem", 8'h02, 8'h06, 1'b0, 1'b1);
	endtask : t_one_mem
	task automatic t_jump;
		clr();
		cls = instruction_timing_pkg::CLS_JUMP;
		ea_c = 3'h2;
		{pa, pe, flush} = 3'b111;
		bus_wait_control_register = 16'h2246;
		go("jump", 8'h01, 8'h0a, 1'b0, 1'b1);
	endtask : t_jump
	task automatic t_cat;
		clr();
		cls = instruction_timing_pkg::CLS_PERIPH_MOVE;
		{ea_w, cat} = 6'o13;
		{ioa, ioe} = 2'b11;
		bus_wait_control_register = 16'h5000;
		go("periph", 8'h02, 8'h0c, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::CLS_BIT;
		cat = 3'h2;
		go("bit", 8'h01, 8'h06, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::CLS_BIT;
		mac = 1'b1;
		go("bit_round", 8'h00, 8'h00, 1'b1, 1'b0);
	endtask : t_cat
	task automatic t_wait;
		clr();
		cls = instruction_timing_pkg::CLS_WAIT;
		irq = 1'b1;
		go("wait_irq", 8'h01, 8'h10, 1'b0, 1'b1);
		opf = 1'b1;
		go("wait_ops", 8'h00, 8'h00, 1'b1, 1'b0);
	endtask : t_wait
	// Classes and modes the other scenarios leave out, plus a broken class code
	task automatic t_more;
		clr();
		cls = instruction_timing_pkg::CLS_CTRL_MOVE;
		{ea_w, cat} = 6'o11;
		go("ctrl", 8'h02, 8'h03, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::CLS_PROG_MOVE;
		{ea_w, ea_c} = 6'o12;
		{pa, pe} = 2'b11;
		bus_wait_control_register = 16'h0300;
		go("prog", 8'h02, 8'h0b, 1'b0, 1'b1);
		clr();
		mk = instruction_timing_pkg::MV_REG;
		ea_w = 3'h3;
		go("reg_move", 8'h01, 8'h02, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::CLS_JUMP;
		{pa, pe} = 2'b11;
		bus_wait_control_register = 16'h0f00;
		go("jump_full", 8'h01, 8'h04, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::CLS_WAIT;
		go("wait_idle", 8'h01, 8'h02, 1'b0, 1'b1);
		clr();
		cls = instruction_timing_pkg::instr_class_type'(7'h03);
		go("bad_class", 8'h01, 8'h02, 1'b1, 1'b1);
	endtask : t_more
	// Hang guard well above the hundred-odd cycles the tests need
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_fail++;
			summarize();
		end
	end
	initial
	begin
		clr();
		start = 1'b0;
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		chk("reset counts", 8'h00, word_cnt | cyc_cnt);
		chk("reset flags", 8'h00, {5'h00, illegal, busy, done});
		t_walk();
		t_dual_max();
		t_one_mem();
		t_jump();
		t_cat();
		t_wait();
		t_more();
		summarize();
	end
endmodule : tb_top
bind instruction_cycle_timing timing_props #(.CNT_W(CNT_W)) u_timing_props (.CLK_SYS(CLK_SYS),
	.RST_N(RST_N), .START(START), .INSTR_CLASS(INSTR_CLASS), .IS_MAC_ROUND(IS_MAC_ROUND),
	.MOVE_KIND(MOVE_KIND), .OPERAND_FIELDS_PRESENT(OPERAND_FIELDS_PRESENT),
	.EA_EXTRA_CYCLES(EA_EXTRA_CYCLES), .INTERNAL_IRQ_PENDING(INTERNAL_IRQ_PENDING),
	.P_ACCESS(P_ACCESS), .P_EXTERNAL(P_EXTERNAL), .PIPE_FLUSHED(PIPE_FLUSHED),
	.BUS_WAIT_CONTROL(BUS_WAIT_CONTROL), .WORD_COUNT(WORD_COUNT), .CYCLE_COUNT(CYCLE_COUNT),
	.ILLEGAL_ENCODING(ILLEGAL_ENCODING), .BUSY(BUSY), .DONE(DONE));
